// ---- rtl/rtcsp_pkg.sv ----
// Purpose: shared constants and types of the two-wire slave port
// Assumes: 20 MHz core clock, six-bit register pointer over a 64-byte space
// Notes: locations 00-07 are the clock bytes, 08-3f the battery-backed RAM
package rtcsp_pkg;
	localparam int PTR_W = 6;
	localparam int BYTE_W = 8;
	localparam int CLOCK_BYTES = 8;
	localparam int SPACE_BYTES = 64;
	localparam logic [5:0] RAM_FIRST = 6'h08;
	localparam logic [5:0] PTR_RST = 6'h00;
	localparam logic [3:0] BIT_LAST = 4'h7;
	localparam logic [3:0] ACK_SLOT = 4'h8;
	// value after START, so the clock fall that closes the START lands on slot zero
	localparam logic [3:0] BIT_ARMED = 4'hf;
	localparam logic DIR_WRITE = 1'b0;
	localparam logic DIR_READ = 1'b1;
	localparam int DIR_POS = 0;
	localparam int WR_DATA_POS = 0;
	localparam int WR_ADDR_POS = 8;
	localparam int FIFO_W = PTR_W + BYTE_W;
	localparam int FIFO_DEPTH = 8;
	localparam int CLK_NS = 50;
	localparam int HOLD_NS = 300;
	localparam int HOLD_CYC_I = (HOLD_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [3:0] HOLD_CYC = 4'(HOLD_CYC_I);
	localparam logic [2:0] SYNC_RST = 3'h7;
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_WRITE,
		ST_READ,
		ST_IGNORE
	} rtcsp_state_e;
endpackage

// ---- rtl/rtcsp_fifo.sv ----
// Purpose: write-byte FIFO between the serial port and the timekeeping core
// Assumes: depth is a power of two
// Notes: inReady low is the back-pressure that makes the port refuse a byte
`timescale 1ns/10ps
module rtcsp_fifo #(
	parameter int WIDTH = 14,
	parameter int DEPTH = 8
)
(
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

	logic [WIDTH-1:0] mem [0:DEPTH-1];
	logic [AW-1:0] wrPtr_q;
	logic [AW-1:0] rdPtr_q;
	logic [AW:0] count_q;
	logic push;
	logic pop;

	assign inReady = count_q != FULL_CNT;
	assign outValid = count_q != '0;
	assign push = inValid && inReady;
	assign pop = outValid && outReady;
	assign outData = mem[rdPtr_q];

	always_ff @(posedge mclk)
	begin
		if (push)
			mem[wrPtr_q] <= inData;
	end

	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
			count_q <= '0;
		end
		else
		begin
			if (push)
				wrPtr_q <= wrPtr_q + 1'b1;
			if (pop)
				rdPtr_q <= rdPtr_q + 1'b1;
			if (push && !pop)
				count_q <= count_q + 1'b1;
			else if (pop && !push)
				count_q <= count_q - 1'b1;
		end
	end
endmodule // rtcsp_fifo

// ---- rtl/rtcsp_slave.sv ----
// Purpose: two-wire serial slave port of a clock/calendar with RAM
// Assumes: the bus master clocks at or below the standard rate; pins are asynchronous
// Notes: clock bytes are served from a copy taken at each START; writes leave via a FIFO
`timescale 1ns/10ps

module rtcsp_slave #(
	parameter logic [6:0] SLAVE_ADDR = 7'h2a // arbitrary value
)
(
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic sclIn,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOe,
	input wire logic [63:0] timeIn,
	output logic wrValid,
	input wire logic wrReady,
	output logic [5:0] wrAddr,
	output logic [7:0] wrData,
	output logic busy
);
	logic [2:0] sclSync_q;
	logic [2:0] sdaSync_q;
	logic sclF_q;
	logic sdaF_q;
	logic sclNew;
	logic sdaNew;
	logic sclRise;
	logic sclFall;
	logic startEv;
	logic stopEv;
	rtcsp_pkg::rtcsp_state_e state_q;
	logic [3:0] bitCnt_q;
	logic [7:0] shift_q;
	logic [7:0] txShift_q;
	logic isRead_q;
	logic firstData_q;
	logic masterNack_q;
	logic [5:0] ptr_q;
	logic [7:0] shadow_q [0:rtcsp_pkg::CLOCK_BYTES-1];
	logic [7:0] ram [0:rtcsp_pkg::SPACE_BYTES-1];
	logic [7:0] rdByte;
	logic byteDone;
	logic ackDone;
	logic addrMatch;
	logic loadTx;
	logic storeByte;
	logic fifoInReady;
	logic [rtcsp_pkg::FIFO_W-1:0] fifoOut;
	logic driveNext;
	logic pendLow_q;
	logic drvLow_q;
	logic [3:0] holdCnt_q;

	// a line counts as changed once the second and third stages agree
	function automatic logic settle(input logic [2:0] s, input logic prev);
		settle = (s[1] == s[2]) ? s[2] : prev;
	endfunction

	function automatic logic [5:0] nextPtr(input logic [5:0] p);
		nextPtr = p + 6'h01;
	endfunction

	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			sclSync_q <= rtcsp_pkg::SYNC_RST;
			sdaSync_q <= rtcsp_pkg::SYNC_RST;
			sclF_q <= 1'b1;
			sdaF_q <= 1'b1;
		end
		else
		begin
			sclSync_q <= {sclSync_q[1:0], sclIn};
			sdaSync_q <= {sdaSync_q[1:0], sdaIn};
			sclF_q <= sclNew;
			sdaF_q <= sdaNew;
		end
	end

	assign sclNew = settle(sclSync_q, sclF_q);
	assign sdaNew = settle(sdaSync_q, sdaF_q);
	assign sclRise = sclNew && !sclF_q;
	assign sclFall = !sclNew && sclF_q;
	assign startEv = sclF_q && sclNew && sdaF_q && !sdaNew;
	assign stopEv = sclF_q && sclNew && !sdaF_q && sdaNew;

	assign byteDone = sclFall && (bitCnt_q == rtcsp_pkg::BIT_LAST);
	assign ackDone = sclFall && (bitCnt_q == rtcsp_pkg::ACK_SLOT);
	assign addrMatch = shift_q[7:1] == SLAVE_ADDR;
	assign rdByte = (ptr_q < rtcsp_pkg::RAM_FIRST) ? shadow_q[ptr_q[2:0]] : ram[ptr_q];
	assign loadTx = ackDone && ((state_q == rtcsp_pkg::ST_ADDR && isRead_q)
		|| (state_q == rtcsp_pkg::ST_READ && !masterNack_q));
	assign storeByte = byteDone && (state_q == rtcsp_pkg::ST_WRITE) && !firstData_q && fifoInReady;

	// bit slot counter: eight data slots then the acknowledge slot
	// the fall that ends a START is not a bit, it wraps the armed value to zero
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
			bitCnt_q <= 4'h0;
		else if (startEv)
			bitCnt_q <= rtcsp_pkg::BIT_ARMED;
		else if (sclFall)
			bitCnt_q <= (bitCnt_q == rtcsp_pkg::ACK_SLOT) ? 4'h0 : bitCnt_q + 4'h1;
	end

	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
			shift_q <= 8'h00;
		else if (sclRise && bitCnt_q != rtcsp_pkg::ACK_SLOT)
			shift_q <= {shift_q[6:0], sdaNew};
	end

	// transfer state; START wins over everything, repeated or not
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
			state_q <= rtcsp_pkg::ST_IDLE;
		else if (startEv)
			state_q <= rtcsp_pkg::ST_ADDR;
		else if (stopEv)
			state_q <= rtcsp_pkg::ST_IDLE;
		else
		begin
			unique case (state_q)
				rtcsp_pkg::ST_IDLE,
				rtcsp_pkg::ST_IGNORE:
					state_q <= state_q;
				rtcsp_pkg::ST_ADDR:
					if (byteDone && !addrMatch)
						state_q <= rtcsp_pkg::ST_IGNORE;
					else if (ackDone)
						state_q <= isRead_q ? rtcsp_pkg::ST_READ : rtcsp_pkg::ST_WRITE;
				rtcsp_pkg::ST_WRITE:
					state_q <= state_q;
				rtcsp_pkg::ST_READ:
					if (ackDone && masterNack_q)
						state_q <= rtcsp_pkg::ST_IGNORE;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			isRead_q <= rtcsp_pkg::DIR_WRITE;
			firstData_q <= 1'b0;
		end
		else
		begin
			if (byteDone && state_q == rtcsp_pkg::ST_ADDR)
				isRead_q <= shift_q[rtcsp_pkg::DIR_POS];
			if (ackDone && state_q == rtcsp_pkg::ST_ADDR)
				firstData_q <= 1'b1;
			else if (byteDone && state_q == rtcsp_pkg::ST_WRITE)
				firstData_q <= 1'b0;
		end
	end

	// master's answer in the acknowledge slot of a read
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
			masterNack_q <= 1'b0;
		else if (sclRise && bitCnt_q == rtcsp_pkg::ACK_SLOT && state_q == rtcsp_pkg::ST_READ)
			masterNack_q <= sdaNew;
	end

	// pointer survives between transfers, so a bare read resumes where it stood
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
			ptr_q <= rtcsp_pkg::PTR_RST;
		else if (byteDone && state_q == rtcsp_pkg::ST_WRITE && firstData_q)
			ptr_q <= shift_q[5:0];
		else if (storeByte || loadTx)
			ptr_q <= nextPtr(ptr_q);
	end

	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
			txShift_q <= 8'h00;
		else if (loadTx)
			txShift_q <= rdByte;
		else if (sclFall && state_q == rtcsp_pkg::ST_READ && bitCnt_q < rtcsp_pkg::BIT_LAST)
			txShift_q <= {txShift_q[6:0], 1'b0};
	end

	// snapshot of the running time at every START
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			for (int i = 0; i < rtcsp_pkg::CLOCK_BYTES; i++)
				shadow_q[i] <= 8'h00;
		end
		else if (startEv)
		begin
			for (int i = 0; i < rtcsp_pkg::CLOCK_BYTES; i++)
				shadow_q[i] <= timeIn[8*i +: 8];
		end
	end

	always_ff @(posedge mclk)
	begin
		if (storeByte && ptr_q >= rtcsp_pkg::RAM_FIRST)
			ram[ptr_q] <= shift_q;
	end

	// level to drive once the hold time after this falling edge has passed
	always_comb
	begin
		driveNext = 1'b0;
		if (byteDone)
		begin
			unique case (state_q)
				rtcsp_pkg::ST_ADDR:
					driveNext = addrMatch;
				rtcsp_pkg::ST_WRITE:
					driveNext = firstData_q || fifoInReady;
				default:
					driveNext = 1'b0;
			endcase
		end
		else if (loadTx)
			driveNext = !rdByte[7];
		else if (sclFall && state_q == rtcsp_pkg::ST_READ && bitCnt_q < rtcsp_pkg::BIT_LAST)
			driveNext = !txShift_q[6];
		else
			driveNext = 1'b0;
	end

	// every change of the pin after a clock fall waits out the hold time; START and STOP release it at once
	always_ff @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			pendLow_q <= 1'b0;
			drvLow_q <= 1'b0;
			holdCnt_q <= 4'h0;
		end
		else if (startEv || stopEv)
		begin
			pendLow_q <= 1'b0;
			drvLow_q <= 1'b0;
			holdCnt_q <= 4'h0;
		end
		else if (sclFall)
		begin
			pendLow_q <= driveNext;
			holdCnt_q <= rtcsp_pkg::HOLD_CYC;
		end
		else if (holdCnt_q != 4'h0)
		begin
			holdCnt_q <= holdCnt_q - 4'h1;
			if (holdCnt_q == 4'h1)
				drvLow_q <= pendLow_q;
		end
	end

	assign sdaOut = 1'b0;
	assign sdaOe = drvLow_q;
	assign busy = state_q != rtcsp_pkg::ST_IDLE;

	rtcsp_fifo #(
		.WIDTH(rtcsp_pkg::FIFO_W),
		.DEPTH(rtcsp_pkg::FIFO_DEPTH)
	) writeFifo (
		.mclk(mclk),
		.rst_b(rst_b),
		.inValid(storeByte),
		.inReady(fifoInReady),
		.inData({ptr_q, shift_q}),
		.outValid(wrValid),
		.outReady(wrReady),
		.outData(fifoOut)
	);

	assign wrAddr = fifoOut[rtcsp_pkg::WR_ADDR_POS +: rtcsp_pkg::PTR_W];
	assign wrData = fifoOut[rtcsp_pkg::WR_DATA_POS +: rtcsp_pkg::BYTE_W];
endmodule // rtcsp_slave

// ---- tb/rtcsp_slave_monitor.sv ----
// Purpose: bus-side and write-queue checks of the slave port
// Assumes: pins sampled raw at mclk
// Notes: bound to every rtcsp_slave
`timescale 1ns/10ps
module rtcsp_slave_monitor (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic sclIn,
	input wire logic sdaIn,
	input wire logic sdaOut,
	input wire logic sdaOe,
	input wire logic [63:0] timeIn,
	input wire logic wrValid,
	input wire logic wrReady,
	input wire logic [5:0] wrAddr,
	input wire logic [7:0] wrData,
	input wire logic busy
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	property p_od; sdaOut == 1'b0; endproperty
	a_od: assert property (p_od) else $error("data output not zero");
	property p_chg; $changed(sdaOe) |-> !sclIn; endproperty
	a_chg: assert property (p_chg) else $error("data drive moved in clock high");
	property p_start; $rose(busy) |-> sclIn && !sdaIn; endproperty
	a_start: assert property (p_start) else $error("busy without start");
	property p_stop; $fell(busy) |-> sclIn && sdaIn; endproperty
	a_stop: assert property (p_stop) else $error("busy ended without stop");
	property p_hold; $fell(sclIn) && sdaOe |-> sdaOe [*8]; endproperty
	a_hold: assert property (p_hold) else $error("drive dropped in hold");
	property p_wrv; $rose(wrValid) |-> busy; endproperty
	a_wrv: assert property (p_wrv) else $error("byte stored outside transfer");
	property p_keep; wrValid && !wrReady |=> wrValid && $stable(wrAddr) && $stable(wrData); endproperty
	a_keep: assert property (p_keep) else $error("queued byte lost");
	property p_idle; !busy && !$past(busy) |-> !sdaOe; endproperty
	a_idle: assert property (p_idle) else $error("drive while idle");
endmodule // rtcsp_slave_monitor
bind rtcsp_slave rtcsp_slave_monitor rtcsp_slave_monitor_i (.mclk(mclk), .rst_b(rst_b), .sclIn(sclIn),
	.sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .timeIn(timeIn), .wrValid(wrValid), .wrReady(wrReady),
	.wrAddr(wrAddr), .wrData(wrData), .busy(busy));

// ---- tb/rtcsp_master_model.sv ----
// Purpose: behavioural bus master for the slave port
// Assumes: line pulled up; sdaLow pulls it down
// Notes: phases counted in mclk falling edges
`timescale 1ns/10ps
module rtcsp_master_model (
	input wire logic mclk,
	input wire logic sda,
	output logic scl,
	output logic sdaLow
);
	initial
	begin
		scl = 1'b1;
		sdaLow = 1'b0;
	end
	task automatic w(input int n);
		repeat (n) @(negedge mclk);
	endtask
	// data moves in low phase, sampled mid high phase; 200 cycles a bit is the 100 kHz standard rate
	task automatic bitx(input logic b, output logic r);
		w(50);
		sdaLow = !b;
		w(50);
		scl = 1'b1;
		w(50);
		r = sda;
		w(50);
		scl = 1'b0;
	endtask
	// also a repeated start
	task automatic start;
		w(50);
		sdaLow = 1'b0;
		w(50);
		scl = 1'b1;
		w(100);
		sdaLow = 1'b1;
		w(100);
		scl = 1'b0;
	endtask
	task automatic stop;
		w(50);
		sdaLow = 1'b1;
		w(50);
		scl = 1'b1;
		w(100);
		sdaLow = 1'b0;
		w(100);
	endtask
	task automatic xfer(input logic [7:0] d, input logic m, output logic [7:0] q, output logic a);
		for (int i = 7; i >= 0; i--)
			bitx(d[i], q[i]);
		bitx(m, a);
	endtask
endmodule // rtcsp_master_model

// ---- tb/tb_rtcsp_slave.sv ----
// Purpose: self-checking bench of the slave port
// Assumes: bus bit of 200 mclk cycles
// Notes: consumer stalls during writes
`timescale 1ns/10ps
`define CHK(g, e) begin cmpCount++; if ((g) !== (e)) begin mismatches++; $display("MISMATCH t=%0t got %h want %h", $time, g, e); end end
module tb_rtcsp_slave;
	localparam logic [6:0] ADR = 7'h2a; // arbitrary value
	logic mclk = 0, rst_b = 0, wrReady = 0, sdaOe, sdaOut, wrValid, busy, scl, sdaLow, a;
	logic [63:0] timeIn = 64'h0;
	logic [5:0] wrAddr;
	logic [7:0] wrData, q;
	wire sda = !(sdaLow || sdaOe);
	int mismatches = 0, cmpCount = 0, cyc = 0;
	rtcsp_slave #(.SLAVE_ADDR(ADR)) rtcsp_slave_i (.mclk(mclk), .rst_b(rst_b), .sclIn(scl), .sdaIn(sda),
		.sdaOut(sdaOut), .sdaOe(sdaOe), .timeIn(timeIn), .wrValid(wrValid), .wrReady(wrReady),
		.wrAddr(wrAddr), .wrData(wrData), .busy(busy));
	rtcsp_master_model rtcsp_master_model_i (.mclk(mclk), .sda(sda), .scl(scl), .sdaLow(sdaLow));
	always #25 mclk = !mclk;
	task automatic st;
		rtcsp_master_model_i.start;
	endtask
	task automatic sp;
		rtcsp_master_model_i.stop;
	endtask
	task automatic x(input logic [7:0] d, input logic m);
		rtcsp_master_model_i.xfer(d, m, q, a);
	endtask
	task automatic final_report;
		if (mismatches == 0 && cmpCount > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic t_bad;
		st;
		x({ADR ^ 7'h01, 1'b0}, 1'b1);
		`CHK(a, 1'b1)
		x(8'h00, 1'b1);
		`CHK(a, 1'b1)
		sp;
		`CHK(wrValid, 1'b0)
	endtask
	task automatic t_write;
		st;
		x({ADR, 1'b0}, 1'b1);
		`CHK(a, 1'b0)
		x(8'h3e, 1'b1);
		`CHK(a, 1'b0)
		// ninth byte meets a full queue
		for (int i = 0; i < 9; i++)
		begin
			x(8'h10 + 8'(i), 1'b1);
			`CHK(a, i == 8)
		end
		sp;
		`CHK(busy, 1'b0)
		for (int i = 0; i < 8; i++)
		begin
			`CHK({wrValid, wrAddr, wrData}, {1'b1, 6'h3e + 6'(i), 8'h10 + 8'(i)})
			wrReady = 1'b1;
			@(negedge mclk);
		end
		wrReady = 1'b0;
		`CHK(wrValid, 1'b0)
	endtask
	task automatic t_read;
		st;
		x({ADR, 1'b0}, 1'b1);
		x(8'h3e, 1'b1);
		st;
		x({ADR, 1'b1}, 1'b1);
		`CHK(a, 1'b0)
		x(8'hff, 1'b0);
		`CHK(q, 8'h10)
		x(8'hff, 1'b1);
		`CHK(q, 8'h11)
		x(8'hff, 1'b1);
		`CHK(q, 8'hff)
		sp;
	endtask
	task automatic t_shadow;
		timeIn = 64'h8877665544332211;
		st;
		x({ADR, 1'b1}, 1'b1);
		`CHK(a, 1'b0)
		timeIn = ~timeIn;
		x(8'hff, 1'b0);
		`CHK(q, 8'h11)
		x(8'hff, 1'b1);
		`CHK(q, 8'h22)
		sp;
	endtask
	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 60000)
		begin
			mismatches++;
			final_report;
		end
	end
	initial
	begin
		repeat (6) @(negedge mclk);
		rst_b = 1'b1;
		repeat (4) @(negedge mclk);
		t_bad;
		t_write;
		t_read;
		t_shadow;
		final_report;
	end
endmodule // tb_rtcsp_slave
